// *** inc/cws_pkg.sv ***
// Purpose: Shared constants and types for the control write sequencer
// Assumes: 200 MHz ref_clk, 8-bit control register addresses, 16-bit data
// Notes:   Step memory holds RAM locations then ROM locations
package cws_pkg;

    // Register offsets on the serial control interface
    localparam logic [7:0] CWS_OFS_CONFIG   = 8'h6C;
    localparam logic [7:0] CWS_OFS_FORMAT   = 8'h6D;
    localparam logic [7:0] CWS_OFS_PAYLOAD  = 8'h6E;
    localparam logic [7:0] CWS_OFS_RUN      = 8'h6F;
    localparam logic [7:0] CWS_OFS_PROGRESS = 8'h70;

    // Field positions
    localparam int CWS_BIT_ENABLE   = 8;
    localparam int CWS_BIT_LAUNCH   = 8;
    localparam int CWS_BIT_CANCEL   = 9;
    localparam int CWS_BIT_LAST     = 14;
    localparam int CWS_BIT_RUNNING  = 0;
    localparam int CWS_LSB_RECENT   = 4;

    // Memory map of the step store
    localparam int CWS_RAM_DEPTH    = 32;
    localparam int CWS_ROM_FIRST    = 32;
    localparam int CWS_ROM_LAST     = 48;

    // Timing: one tick is 62.5 us
    localparam int CWS_TICK_NS      = 62500;
    localparam int CWS_CLK_NS       = 5;
    localparam int CWS_TICK_CYCLES  = CWS_TICK_NS / CWS_CLK_NS;
    localparam int CWS_WAIT_BIAS    = 8;

    // Reset values
    localparam logic [15:0] CWS_RST_WORD = 16'h0000;
    localparam logic [5:0]  CWS_RST_LOC  = 6'h00;

    typedef struct packed {
        logic [2:0] widthCode;   // field_width_code
        logic [3:0] lsbPos;      // field_lsb_position
        logic [7:0] target;      // target_register_select
    } cws_format_s;

    typedef struct packed {
        logic       lastStep;    // last_step_flag
        logic [3:0] waitCode;    // step_wait_code
        logic [7:0] value;       // step_payload_value
    } cws_payload_s;

    typedef struct packed {
        cws_format_s  fmt;
        cws_payload_s pay;
    } cws_step_s;

    typedef enum logic [2:0] {
        CWS_IDLE,
        CWS_FETCH,
        CWS_ADDR,
        CWS_MODIFY,
        CWS_WAIT
    } cws_state_e;

endpackage

// *** rtl/cws_control_write_sequencer.sv ***
// Purpose: Runs stored register-write steps on the device's control registers
// Assumes: Register file answers regRdData combinationally for regAddr
// Notes:   Host writes to other registers are forwarded only while idle
`timescale 1ns/1ps

// Overview of operation
// - Width code 14:12 selects 1..8 bits
// - Bits 11:8 give field LSB position
// - Bits 7:0 give target register address
// - Last-step bit 14 stops after step
// - Step lasts 62.5us times (2^code+8)
// - Value from bits 7:0, extra MSBs ignored
// - Cancel bit 9 stops sequence immediately
// - Launch bit 8 starts at launch location
// - Launch bit self-clears at sequence end
// - Locations: 0-31 RAM, 32-48 ROM, rest reserved
// - Progress bits 9:4 show recent location
// - Progress bit 0 shows running
// - Host register writes blocked while running
// - Engine works only when enable set
// - Format/payload writes copied to load location
module cws_control_write_sequencer #(
    parameter int TICK_CYCLES = cws_pkg::CWS_TICK_CYCLES
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Serial control interface, decoded
    input  wire logic        hostWrEn,
    input  wire logic        hostRdEn,
    input  wire logic [7:0]  hostAddr,
    input  wire logic [15:0] hostWrData,
    output logic      [15:0] hostRdData,
    // Device control register port
    output logic             regWrEn,
    output logic      [7:0]  regAddr,
    output logic      [15:0] regWrData,
    input  wire logic [15:0] regRdData
);

    cws_pkg::cws_step_s    ram [cws_pkg::CWS_RAM_DEPTH];
    cws_pkg::cws_state_e   state;
    cws_pkg::cws_state_e   next_state;
    cws_pkg::cws_format_s  fmtReg;
    cws_pkg::cws_format_s  next_fmtReg;
    cws_pkg::cws_payload_s payReg;
    cws_pkg::cws_payload_s next_payReg;
    cws_pkg::cws_step_s    step;
    cws_pkg::cws_step_s    next_step;
    logic                  engineEnable;
    logic                  next_engineEnable;
    logic [4:0]            loadLocation;
    logic [4:0]            next_loadLocation;
    logic                  launch;
    logic                  next_launch;
    logic [5:0]            launchLocation;
    logic [5:0]            next_launchLocation;
    logic [5:0]            recentLocation;
    logic [5:0]            next_recentLocation;
    logic [15:0]           tickCnt;
    logic [15:0]           next_tickCnt;
    logic [15:0]           stepTicks;
    logic [15:0]           next_stepTicks;
    logic [15:0]           next_hostRdData;
    logic                  next_regWrEn;
    logic [7:0]            next_regAddr;
    logic [15:0]           next_regWrData;
    logic                  ramWrEn;
    logic                  busy;
    logic                  hostHit;
    logic                  stepDone;

    // ROM contents live outside this block; every ROM location ends a sequence
    function automatic cws_pkg::cws_step_s romStep(input logic [5:0] loc);
        cws_pkg::cws_step_s s;
        s = '0;
        s.pay.lastStep = (loc <= 6'(cws_pkg::CWS_ROM_LAST));
        return s;
    endfunction

    function automatic cws_pkg::cws_step_s readStep(input logic [5:0] loc);
        cws_pkg::cws_step_s s;
        if (loc < 6'(cws_pkg::CWS_ROM_FIRST))
            s = ram[loc[4:0]];
        else
            s = romStep(loc);
        return s;
    endfunction

    // Field mask aligned to bit 0, one to eight bits wide
    function automatic logic [15:0] fieldMask(input logic [2:0] code);
        logic [15:0] m;
        m = (16'h0002 << code) - 16'h0001;
        return m;
    endfunction

    function automatic logic [15:0] mergeField(input cws_pkg::cws_step_s s, input logic [15:0] old);
        logic [15:0] m;
        logic [15:0] v;
        m = fieldMask(s.fmt.widthCode) << s.fmt.lsbPos;
        v = ({8'h00, s.pay.value} & fieldMask(s.fmt.widthCode)) << s.fmt.lsbPos;
        return (old & ~m) | v;
    endfunction

    assign busy     = (state != cws_pkg::CWS_IDLE);
    assign hostHit  = (hostAddr >= cws_pkg::CWS_OFS_CONFIG) && (hostAddr <= cws_pkg::CWS_OFS_PROGRESS);
    assign ramWrEn  = hostWrEn && ((hostAddr == cws_pkg::CWS_OFS_FORMAT) || (hostAddr == cws_pkg::CWS_OFS_PAYLOAD));
    // Counts whole ticks; execution cycles fall inside the first tick
    assign stepDone = (tickCnt == 16'(TICK_CYCLES - 1))
                   && (stepTicks == (16'h0001 << step.pay.waitCode) + 16'(cws_pkg::CWS_WAIT_BIAS - 1));

    always_comb
    begin
        next_state          = state;
        next_fmtReg         = fmtReg;
        next_payReg         = payReg;
        next_step           = step;
        next_engineEnable   = engineEnable;
        next_loadLocation   = loadLocation;
        next_launch         = launch;
        next_launchLocation = launchLocation;
        next_recentLocation = recentLocation;
        next_tickCnt        = tickCnt;
        next_stepTicks      = stepTicks;
        next_hostRdData     = hostRdData;
        next_regWrEn        = 1'b0;
        next_regAddr        = regAddr;
        next_regWrData      = regWrData;

        if (hostRdEn)
        begin
            unique case (hostAddr)
                cws_pkg::CWS_OFS_CONFIG:   next_hostRdData = {7'h00, engineEnable, 3'h0, loadLocation};
                cws_pkg::CWS_OFS_FORMAT:   next_hostRdData = {1'b0, fmtReg};
                cws_pkg::CWS_OFS_PAYLOAD:  next_hostRdData = {1'b0, payReg.lastStep, 2'h0,
                                                              payReg.waitCode, payReg.value};
                cws_pkg::CWS_OFS_RUN:      next_hostRdData = {6'h00, 1'b0, launch, 2'h0, launchLocation};
                cws_pkg::CWS_OFS_PROGRESS: next_hostRdData = {6'h00, recentLocation, 3'h0, busy};
                default:                   next_hostRdData = cws_pkg::CWS_RST_WORD;
            endcase
        end

        // Sequencer engine
        next_tickCnt = (tickCnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tickCnt + 16'h0001;
        if (tickCnt == 16'(TICK_CYCLES - 1))
            next_stepTicks = stepTicks + 16'h0001;
        unique case (state)
            cws_pkg::CWS_IDLE:
            begin
                next_tickCnt   = 16'h0000;
                next_stepTicks = 16'h0000;
            end
            cws_pkg::CWS_FETCH:
            begin
                next_step           = readStep(recentLocation);
                next_state          = cws_pkg::CWS_ADDR;
            end
            cws_pkg::CWS_ADDR:
            begin
                next_regAddr = step.fmt.target;
                next_state   = cws_pkg::CWS_MODIFY;
            end
            cws_pkg::CWS_MODIFY:
            begin
                next_regWrEn   = 1'b1;
                next_regWrData = mergeField(step, regRdData);
                next_state     = cws_pkg::CWS_WAIT;
            end
            cws_pkg::CWS_WAIT:
            begin
                if (stepDone)
                begin
                    next_tickCnt   = 16'h0000;
                    next_stepTicks = 16'h0000;
                    if (step.pay.lastStep)
                    begin
                        next_state  = cws_pkg::CWS_IDLE;
                        next_launch = 1'b0;
                    end
                    else
                    begin
                        next_recentLocation = recentLocation + 6'h01;
                        next_state          = cws_pkg::CWS_FETCH;
                    end
                end
            end
        endcase

        // Host register writes; own registers stay writable while running
        if (hostWrEn)
        begin
            unique case (hostAddr)
                cws_pkg::CWS_OFS_CONFIG:
                begin
                    next_engineEnable = hostWrData[cws_pkg::CWS_BIT_ENABLE];
                    next_loadLocation = hostWrData[4:0];
                end
                cws_pkg::CWS_OFS_FORMAT:  next_fmtReg = hostWrData[14:0];
                cws_pkg::CWS_OFS_PAYLOAD: next_payReg = {hostWrData[cws_pkg::CWS_BIT_LAST], hostWrData[11:0]};
                cws_pkg::CWS_OFS_RUN:
                begin
                    next_launchLocation = hostWrData[5:0];
                    if (hostWrData[cws_pkg::CWS_BIT_CANCEL])
                    begin
                        next_state  = cws_pkg::CWS_IDLE;
                        next_launch = 1'b0;
                    end
                    else if (hostWrData[cws_pkg::CWS_BIT_LAUNCH] && !busy && engineEnable
                             && (hostWrData[5:0] <= 6'(cws_pkg::CWS_ROM_LAST)))
                    begin
                        next_launch         = 1'b1;
                        next_recentLocation = hostWrData[5:0];
                        next_state          = cws_pkg::CWS_FETCH;
                    end
                end
                default:
                begin
                    if (!hostHit && !busy)
                    begin
                        next_regWrEn   = 1'b1;
                        next_regAddr   = hostAddr;
                        next_regWrData = hostWrData;
                    end
                end
            endcase
        end

        // Clearing the enable stops a running sequence
        if (!next_engineEnable)
        begin
            next_state  = cws_pkg::CWS_IDLE;
            next_launch = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state          <= cws_pkg::CWS_IDLE;
            fmtReg         <= '0;
            payReg         <= '0;
            step           <= '0;
            engineEnable   <= 1'b0;
            loadLocation   <= 5'h00;
            launch         <= 1'b0;
            launchLocation <= cws_pkg::CWS_RST_LOC;
            recentLocation <= cws_pkg::CWS_RST_LOC;
            tickCnt        <= 16'h0000;
            stepTicks      <= 16'h0000;
            hostRdData     <= cws_pkg::CWS_RST_WORD;
            regWrEn        <= 1'b0;
            regAddr        <= 8'h00;
            regWrData      <= cws_pkg::CWS_RST_WORD;
        end
        else
        begin
            state          <= next_state;
            fmtReg         <= next_fmtReg;
            payReg         <= next_payReg;
            step           <= next_step;
            engineEnable   <= next_engineEnable;
            loadLocation   <= next_loadLocation;
            launch         <= next_launch;
            launchLocation <= next_launchLocation;
            recentLocation <= next_recentLocation;
            tickCnt        <= next_tickCnt;
            stepTicks      <= next_stepTicks;
            hostRdData     <= next_hostRdData;
            regWrEn        <= next_regWrEn;
            regAddr        <= next_regAddr;
            regWrData      <= next_regWrData;
        end
    end

    // Step store has no reset; contents undefined until loaded
    always_ff @(posedge ref_clk)
    begin
        if (ramWrEn)
            ram[loadLocation] <= {next_fmtReg, next_payReg};
    end

endmodule // cws_control_write_sequencer

// *** tb/cws_regfile_model.sv ***
// Purpose: Device control register file behind the sequencer
// Assumes: Read data follows regAddr in the same cycle
// Notes:   Bench preloads random contents so merges show
`timescale 1ns/1ps
module cws_regfile_model (
    // Clock
    input  wire logic        ref_clk,
    // Register port
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData
);
    logic [15:0] mem [256];
    // Same-cycle read feeds the merge
    assign regRdData = mem[regAddr];
    always @(posedge ref_clk)
    begin
        if (regWrEn)
            mem[regAddr] <= regWrData;
    end
endmodule // cws_regfile_model

// *** tb/cws_monitor.sv ***
// Purpose: Port-level checks of the control write sequencer
// Assumes: Sequencer writes never coincide with forwarded ones
// Notes:   Writes not preceded by a host write are the engine's
`timescale 1ns/1ps
module cws_monitor #(
    parameter int TICK_CYCLES = 4
)(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Host side
    input wire logic        hostWrEn,
    input wire logic        hostRdEn,
    input wire logic [7:0]  hostAddr,
    input wire logic [15:0] hostWrData,
    input wire logic [15:0] hostRdData,
    // Register file side
    input wire logic        regWrEn,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData
);
    logic hostWrQ;
    logic seenWr;
    int   gap;
    logic seqWr;
    assign seqWr = regWrEn && !hostWrQ;
    always_ff @(posedge ref_clk)
    begin
        hostWrQ <= rst ? 1'b0 : hostWrEn;
        seenWr  <= rst ? 1'b0 : (seenWr || seqWr);
        gap     <= (rst || seqWr) ? 1 : gap + 1;
    end
    chk_cancel_reads_low: assert property (@(posedge ref_clk) disable iff (rst)
        hostRdEn && hostAddr == 8'h6F |=> !hostRdData[9]) else $error("cancel bit read back set");
    chk_progress_spare: assert property (@(posedge ref_clk) disable iff (rst)
        hostRdEn && hostAddr == 8'h70 |=> hostRdData[15:10] == 6'h00 && hostRdData[3:1] == 3'h0)
        else $error("progress spare bits set");
    chk_run_spare: assert property (@(posedge ref_clk) disable iff (rst)
        hostRdEn && hostAddr == 8'h6F |=> hostRdData[15:10] == 6'h00 && hostRdData[7:6] == 2'h0)
        else $error("run control spare bits set");
    chk_step_gap: assert property (@(posedge ref_clk) disable iff (rst)
        seqWr && seenWr |-> gap >= 9 * TICK_CYCLES) else $error("steps too close");
    chk_rmw_addr_held: assert property (@(posedge ref_clk) disable iff (rst)
        seqWr |-> $stable(regAddr)) else $error("address moved during merge");
    chk_seq_one_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        seqWr && !hostWrEn |=> !regWrEn) else $error("engine write longer than one cycle");
    chk_fwd_copy: assert property (@(posedge ref_clk) disable iff (rst)
        regWrEn && $past(hostWrEn) && regAddr == $past(hostAddr) |-> regWrData == $past(hostWrData))
        else $error("forwarded data altered");
    chk_progress_ro: assert property (@(posedge ref_clk) disable iff (rst)
        hostWrEn && hostAddr == 8'h70 |=> !(regWrEn && regAddr == 8'h70)) else $error("progress written");
endmodule // cws_monitor
bind cws_control_write_sequencer cws_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_cws_monitor (
    .ref_clk(ref_clk), .rst(rst), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the control write sequencer
// Assumes: Inputs change on the falling clock edge
// Notes:   Short tick keeps the step timing exact but fast
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            errCount++; \
            $display("wrong value at %0t: got %h want %h", $time, got, exp); \
        end \
    end
module testbench;
    localparam int TICK = 4;
    logic        ref_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic        hostWrEn   = 1'b0;
    logic        hostRdEn   = 1'b0;
    logic [7:0]  hostAddr   = 8'h00;
    logic [15:0] hostWrData = 16'h0000;
    logic [15:0] hostRdData;
    logic        regWrEn;
    logic [7:0]  regAddr;
    logic [15:0] regWrData;
    logic [15:0] regRdData;
    int          errCount   = 0;
    int          compares   = 0;
    int          seed       = 32'hFC1579C4;
    int          cyc        = 0;
    bit          logOn      = 1'b0;
    int          wrCyc[$];
    logic [7:0]  wrAddr[$];
    int          wcs[8];
    logic [15:0] expv[8];
    logic [15:0] d;
    always #2.5 ref_clk = ~ref_clk;
    cws_control_write_sequencer #(.TICK_CYCLES(TICK)) i_cws_control_write_sequencer (
        .ref_clk(ref_clk), .rst(rst), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn), .hostAddr(hostAddr),
        .hostWrData(hostWrData), .hostRdData(hostRdData), .regWrEn(regWrEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData));
    cws_regfile_model i_cws_regfile_model (
        .ref_clk(ref_clk), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (logOn && regWrEn === 1'b1)
        begin
            wrCyc.push_back(cyc);
            wrAddr.push_back(regAddr);
        end
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic hw(input logic [7:0] a, input logic [15:0] v);
        @(negedge ref_clk);
        hostWrEn = 1'b1;
        hostAddr = a;
        hostWrData = v;
        @(negedge ref_clk);
        hostWrEn = 1'b0;
    endtask
    task automatic hr(input logic [7:0] a, output logic [15:0] q);
        @(negedge ref_clk);
        hostRdEn = 1'b1;
        hostAddr = a;
        @(negedge ref_clk);
        q = hostRdData;
        hostRdEn = 1'b0;
    endtask
    task automatic waitIdle();
        logic [15:0] q;
        repeat (2000)
        begin
            hr(8'h70, q);
            if (q[0] === 1'b0)
                return;
        end
        `CHK(1'b1, 1'b0)
        give_verdict();
    endtask
    initial
    begin
        int w, l, v, m;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        for (int k = 0; k < 256; k++)
            i_cws_regfile_model.mem[k] = 16'($random(seed));
        v = $random(seed);
        hw(8'h31, 16'(v));
        @(negedge ref_clk);
        `CHK(i_cws_regfile_model.mem[8'h31], 16'(v))
        $display("test forward done");
        for (int i = 0; i < 8; i++)
        begin
            w = i;
            l = $random(seed) & 15;
            v = $random(seed) & 255;
            m = (2 << w) - 1;
            if (i % 2)
                v = v & m; // Odd steps zero the unused value bits
            wcs[i] = $random(seed) & 3;
            expv[i] = 16'((i_cws_regfile_model.mem[32 + i] & ~(m << l)) | ((v & m) << l));
            hw(8'h6C, 16'h0100 | 16'(i));
            hw(8'h6D, 16'((w << 12) | (l << 8) | (32 + i)));
            hw(8'h6E, 16'(((i == 7) << 14) | (wcs[i] << 8) | v));
        end
        logOn = 1'b1;
        hw(8'h6F, 16'h0100);
        hr(8'h70, d);
        `CHK(d, 16'h0001)
        hr(8'h6F, d);
        `CHK(d[8], 1'b1)
        hw(8'h30, 16'hA5A5);
        waitIdle();
        logOn = 1'b0;
        `CHK(i_cws_regfile_model.mem[8'h30] === 16'hA5A5, 1'b0)
        hr(8'h70, d);
        `CHK(d, 16'h0070)
        hr(8'h6F, d);
        `CHK(d[8], 1'b0)
        `CHK(wrCyc.size(), 8)
        for (int i = 0; i < 8; i++)
        begin
            `CHK(i_cws_regfile_model.mem[32 + i], expv[i])
            `CHK(wrAddr[i], 8'(32 + i))
            if (i > 0)
                `CHK(wrCyc[i] - wrCyc[i - 1], TICK * ((1 << wcs[i - 1]) + 8))
        end
        $display("test sequence done");
        foreach (expv[i])
        begin
            i_cws_regfile_model.mem[0] = 16'hFFFF;
            hw(8'h6F, (i % 2) ? 16'h0130 : 16'h0120);
            waitIdle();
            `CHK(i_cws_regfile_model.mem[0], 16'hFFFE)
            if (i == 1)
                break;
        end
        hw(8'h6F, 16'h0131);
        hr(8'h70, d);
        `CHK(d[0], 1'b0)
        hw(8'h6F, 16'h013F);
        hr(8'h70, d);
        `CHK(d[0], 1'b0)
        $display("test rom done");
        hw(8'h6C, 16'h0100);
        hw(8'h6E, 16'h0300);
        hw(8'h6F, 16'h0100);
        repeat (10) @(negedge ref_clk);
        hr(8'h70, d);
        `CHK(d[0], 1'b1)
        hw(8'h6F, 16'h0200);
        hr(8'h70, d);
        `CHK(d[0], 1'b0)
        hr(8'h6F, d);
        `CHK(d[9:8], 2'b00)
        hw(8'h31, 16'h5A5A);
        @(negedge ref_clk);
        `CHK(i_cws_regfile_model.mem[8'h31], 16'h5A5A)
        hw(8'h6F, 16'h0300);
        hr(8'h70, d);
        `CHK(d[0], 1'b0)
        hw(8'h6C, 16'h0000);
        hw(8'h6F, 16'h0100);
        hr(8'h70, d);
        `CHK(d[0], 1'b0)
        hw(8'h70, 16'h03F1);
        hr(8'h70, d);
        `CHK(d, 16'h0000)
        `CHK(i_cws_regfile_model.mem[8'h70] === 16'h03F1, 1'b0)
        hw(8'h6C, 16'h0100);
        hw(8'h6F, 16'h0100);
        hr(8'h70, d);
        `CHK(d[0], 1'b1)
        hw(8'h6C, 16'h0000); // Disable mid-step stops the run
        hr(8'h70, d);
        `CHK(d[0], 1'b0)
        $display("test cancel done");
        give_verdict();
    end
endmodule // testbench
